// File: rtl/uart_flow_control_irq.sv
// Decided for this implementation: the address map and register access over AHB-Lite.
`timescale 1ns/1ns
module uart_flow_control_irq
  import uart_flow_pkg::*;
#(
  parameter int FIFO_DEPTH = 64
) (
  input  wire logic        hclk,              // bus clock
  input  wire logic        hresetn,           // async reset, low
  input  wire logic        hsel,              // slave select
  input  wire logic [31:0] haddr,             // byte address
  input  wire logic [1:0]  htrans,            // transfer type
  input  wire logic        hwrite,            // write flag
  input  wire logic [2:0]  hsize,             // transfer size
  input  wire logic [31:0] hwdata,            // write data
  input  wire logic        hready,            // bus ready in
  output logic      [31:0] hrdata,            // read data
  output logic             hreadyout,         // slave ready
  output logic             hresp,             // always okay
  input  wire logic        rx_char_valid,     // received char pulse
  input  wire logic [7:0]  rx_char_data,      // received char
  input  wire logic [2:0]  rx_char_err,       // break/parity/frame
  input  wire logic [6:0]  rx_fifo_level,     // receive fill
  input  wire logic        tx_fifo_not_empty, // queued data present
  input  wire logic        tx_busy,           // transmitter busy
  input  wire logic        tx_insert_ack,     // inserted char sent
  input  wire logic        cts_n,             // clear to send, low
  input  wire logic [3:0]  irq_ext_raw,       // rx/tx/timeout/error
  output logic             rts_n,             // request, low
  output logic             tx_start_ok,       // may start next byte
  output logic             tx_insert_valid,   // insert char pending
  output logic      [7:0]  tx_insert_data,    // char to insert
  output logic             rx_store,          // store char pulse
  output logic      [7:0]  rx_store_data,     // char to store
  output logic             baud_tick,         // oversample enable
  output logic             bit_tick,          // bit period enable
  output logic             irq                // combined interrupt
);
  import uart_flow_pkg::*;

  port_ctrl_t ctrl_r;
  soft_ctrl_t soft_r;
  logic [15:0] div_int_r;
  logic [5:0]  div_frc_r;
  logic [2:0]  lvl_sel_r;
  logic [IRQ_N-1:0] mask_r;
  logic [IRQ_N-1:0] raw_r;
  logic [7:0]  res1_r;
  logic [7:0]  res2_r;
  logic [7:0]  pau1_r;
  logic [7:0]  pau2_r;
  logic        wr_pend_r;
  logic [7:0]  wr_addr_r;
  logic        paused_r;
  logic        pseq_r;
  logic        rseq_r;
  logic        remote_stopped_r;
  logic        busy_d_r;
  logic [15:0] baud_cnt_r;
  logic [5:0]  frac_acc_r;
  logic [3:0]  ovs_cnt_r;
  ins_state_t  ins_r;
  logic        ins_both_r;
  logic [1:0]  sent_mode_r;

  // watermark in characters for a level select code
  function automatic logic [6:0] trig_level(input logic [2:0] sel);
    case (sel)
      3'h0:    trig_level = 7'(FIFO_DEPTH / 8);
      3'h1:    trig_level = 7'(FIFO_DEPTH / 4);
      3'h2:    trig_level = 7'(FIFO_DEPTH / 2);
      3'h3:    trig_level = 7'(FIFO_DEPTH * 3 / 4);
      default: trig_level = 7'(FIFO_DEPTH * 7 / 8);
    endcase
  endfunction

  logic [6:0] trig;
  logic       at_trig;
  assign trig    = trig_level(lvl_sel_r);
  assign at_trig = rx_fifo_level >= trig;

  // ---------------- bus slave ----------------
  logic addr_ok;
  assign addr_ok = hsel && hready && htrans[1];

  function automatic logic [31:0] read_mux(input logic [7:0] a);
    read_mux = 32'h0000_0000;
    case (a)
      OFS_FLAG: begin
        read_mux[FLAG_BUSY_BIT] = tx_busy;
        read_mux[FLAG_RSTP_BIT] = remote_stopped_r;
      end
      OFS_DIVISOR_INTEGER: read_mux[15:0] = div_int_r;
      OFS_DIVFRC: read_mux[5:0] = div_frc_r;
      OFS_CTRL: begin
        read_mux[CTRL_EN_BIT]  = ctrl_r.en;
        read_mux[CTRL_OVS_BIT] = ctrl_r.ovs8;
        read_mux[CTRL_RTS_BIT] = ctrl_r.rts_en;
        read_mux[CTRL_CTS_BIT] = ctrl_r.cts_en;
      end
      OFS_LEVEL: read_mux[LVL_LSB +: 3] = lvl_sel_r;
      OFS_MASK:  read_mux[IRQ_N-1:0] = mask_r;
      OFS_RAW:   read_mux[IRQ_N-1:0] = raw_r;
      OFS_MIS:   read_mux[IRQ_N-1:0] = raw_r & mask_r;
      OFS_SOFT:  read_mux[6:0] = soft_r;
      OFS_RES1:  read_mux[7:0] = res1_r;
      OFS_RES2:  read_mux[7:0] = res2_r;
      OFS_PAU1:  read_mux[7:0] = pau1_r;
      OFS_PAU2:  read_mux[7:0] = pau2_r;
      default:   read_mux = 32'h0000_0000;
    endcase
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_r <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr_r <= haddr[7:0];
      end
      // unmapped or write address reads back zero
      hrdata <= (addr_ok && !hwrite) ? read_mux(haddr[7:0]) : 32'h0000_0000;
    end
  end

  logic clr_write;
  assign clr_write = wr_pend_r && (wr_addr_r == OFS_CLR);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r    <= CTRL_RESET;
      soft_r    <= SOFT_RESET;
      div_int_r <= 16'h0000;
      div_frc_r <= 6'h00;
      lvl_sel_r <= LVL_RESET;
      mask_r    <= '0;
      res1_r    <= 8'h00;
      res2_r    <= 8'h00;
      pau1_r    <= 8'h00;
      pau2_r    <= 8'h00;
    end else if (wr_pend_r) begin
      case (wr_addr_r)
        OFS_CTRL: begin
          ctrl_r.en     <= hwdata[CTRL_EN_BIT];
          ctrl_r.ovs8   <= hwdata[CTRL_OVS_BIT];
          ctrl_r.rts_en <= hwdata[CTRL_RTS_BIT];
          ctrl_r.cts_en <= hwdata[CTRL_CTS_BIT];
        end
        OFS_DIVISOR_INTEGER: div_int_r <= hwdata[15:0];
        OFS_DIVFRC: div_frc_r <= hwdata[5:0];
        OFS_LEVEL:  lvl_sel_r <= hwdata[LVL_LSB +: 3];
        OFS_MASK:   mask_r <= hwdata[IRQ_N-1:0];
        OFS_SOFT:   soft_r <= hwdata[6:0];
        OFS_RES1:   res1_r <= hwdata[7:0];
        OFS_RES2:   res2_r <= hwdata[7:0];
        OFS_PAU1:   pau1_r <= hwdata[7:0];
        OFS_PAU2:   pau2_r <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // ---------------- baud generation ----------------
  logic [6:0] frac_sum;
  assign frac_sum = {1'b0, frac_acc_r} + {1'b0, div_frc_r};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      baud_cnt_r <= 16'h0000;
      frac_acc_r <= 6'h00;
      baud_tick  <= 1'b0;
    end else if (!ctrl_r.en || div_int_r == 16'h0000) begin
      baud_cnt_r <= 16'h0000;
      frac_acc_r <= 6'h00;
      baud_tick  <= 1'b0;
    end else if (baud_cnt_r == 16'h0000) begin
      // period of int cycles, one extra on fraction carry
      baud_cnt_r <= div_int_r - 16'h0001 + {15'h0000, frac_sum[6]};
      frac_acc_r <= frac_sum[5:0];
      baud_tick  <= 1'b1;
    end else begin
      baud_cnt_r <= baud_cnt_r - 16'h0001;
      baud_tick  <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovs_cnt_r <= 4'h0;
      bit_tick  <= 1'b0;
    end else begin
      bit_tick <= 1'b0;
      if (baud_tick) begin
        if (ovs_cnt_r >= (ctrl_r.ovs8 ? OVS8_LAST : OVS16_LAST)) begin
          ovs_cnt_r <= 4'h0;
          bit_tick  <= 1'b1;
        end else begin
          ovs_cnt_r <= ovs_cnt_r + 4'h1;
        end
      end
    end
  end

  // ---------------- hardware handshake ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rts_n       <= 1'b1;
      tx_start_ok <= 1'b0;
    end else begin
      // request asserted low while below watermark
      rts_n <= ctrl_r.rts_en ? at_trig : 1'b0;
      // start gated only between characters
      tx_start_ok <= ctrl_r.en && tx_fifo_not_empty && !paused_r && !tx_insert_valid
                     && (!ctrl_r.cts_en || !cts_n);
    end
  end

  // ---------------- receive side character matching ----------------
  logic soft_rx;
  logic m_p1;
  logic m_p2;
  logic m_r1;
  logic m_r2;
  logic pause_hit;
  logic resume_hit;
  logic half_pair;
  // error status is deliberately not looked at
  assign soft_rx = soft_r.global && soft_r.rx_mode != 2'b00 && !soft_r.special;
  assign m_p1 = rx_char_data == pau1_r;
  assign m_p2 = rx_char_data == pau2_r;
  assign m_r1 = rx_char_data == res1_r;
  assign m_r2 = rx_char_data == res2_r;

  always_comb begin
    pause_hit  = 1'b0;
    resume_hit = 1'b0;
    half_pair  = 1'b0;
    case (soft_r.rx_mode)
      2'b01: begin
        pause_hit  = m_p1;
        resume_hit = m_r1;
      end
      2'b10: begin
        pause_hit  = m_p2;
        resume_hit = m_r2;
      end
      2'b11: begin
        pause_hit  = pseq_r && m_p2;
        resume_hit = rseq_r && m_r2;
        half_pair  = paused_r ? m_r1 : m_p1;
      end
      default: ;
    endcase
  end

  logic store_nxt;
  logic pause_set;
  logic pause_clr;
  always_comb begin
    store_nxt = 1'b0;
    pause_set = 1'b0;
    pause_clr = 1'b0;
    if (rx_char_valid) begin
      if (soft_r.special) begin
        store_nxt = 1'b1;
        pause_set = m_p2;
      end else if (soft_rx) begin
        if (!paused_r) begin
          pause_set = pause_hit;
          store_nxt = !pause_hit && !half_pair;
        end else if (soft_r.any) begin
          pause_clr = 1'b1;
          store_nxt = 1'b1;
        end else begin
          pause_clr = resume_hit;
          store_nxt = !resume_hit && !half_pair;
        end
      end else begin
        store_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_store      <= 1'b0;
      rx_store_data <= 8'h00;
    end else begin
      rx_store <= store_nxt;
      if (rx_char_valid) begin
        rx_store_data <= rx_char_data;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      paused_r <= 1'b0;
      pseq_r   <= 1'b0;
      rseq_r   <= 1'b0;
    end else if (!soft_rx) begin
      paused_r <= 1'b0;
      pseq_r   <= 1'b0;
      rseq_r   <= 1'b0;
    end else if (rx_char_valid) begin
      if (pause_set) begin
        paused_r <= 1'b1;
      end else if (pause_clr) begin
        paused_r <= 1'b0;
      end
      pseq_r <= m_p1;
      rseq_r <= m_r1;
    end
  end

  // ---------------- pause/resume insertion ----------------
  logic tx_soft;
  assign tx_soft = soft_r.global && soft_r.tx_mode != 2'b00;

  // resume uses the current set while enabled, and the set that carried the pause once disabled
  logic [1:0] res_mode;
  assign res_mode = tx_soft ? soft_r.tx_mode : sent_mode_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ins_r            <= INS_IDLE;
      ins_both_r       <= 1'b0;
      sent_mode_r      <= 2'b00;
      tx_insert_valid  <= 1'b0;
      tx_insert_data   <= 8'h00;
      remote_stopped_r <= 1'b0;
    end else begin
      // same frame settings apply: transmitter treats it as data
      case (ins_r)
        INS_IDLE: begin
          if (tx_soft && at_trig && !remote_stopped_r) begin
            ins_r           <= INS_PAUSE_A;
            sent_mode_r     <= soft_r.tx_mode;
            ins_both_r      <= soft_r.tx_mode == 2'b11;
            tx_insert_valid <= 1'b1;
            tx_insert_data  <= (soft_r.tx_mode == 2'b10) ? pau2_r : pau1_r;
          end else if (remote_stopped_r && (!tx_soft || !at_trig)) begin
            ins_r           <= INS_RESUME_A;
            ins_both_r      <= res_mode == 2'b11;
            tx_insert_valid <= 1'b1;
            tx_insert_data  <= (res_mode == 2'b10) ? res2_r : res1_r;
          end
        end
        INS_PAUSE_A, INS_RESUME_A: begin
          if (tx_insert_ack) begin
            if (ins_both_r) begin
              ins_r          <= (ins_r == INS_PAUSE_A) ? INS_PAUSE_B : INS_RESUME_B;
              tx_insert_data <= (ins_r == INS_PAUSE_A) ? pau2_r : res2_r;
            end else begin
              ins_r            <= INS_IDLE;
              tx_insert_valid  <= 1'b0;
              remote_stopped_r <= ins_r == INS_PAUSE_A;
            end
          end
        end
        INS_PAUSE_B, INS_RESUME_B: begin
          if (tx_insert_ack) begin
            ins_r            <= INS_IDLE;
            tx_insert_valid  <= 1'b0;
            remote_stopped_r <= ins_r == INS_PAUSE_B;
          end
        end
        default: begin
          ins_r           <= INS_IDLE;
          tx_insert_valid <= 1'b0;
        end
      endcase
    end
  end

  // ---------------- interrupts ----------------
  logic clr_txe;
  logic clr_pause;
  assign clr_txe   = clr_write && hwdata[IRQ_TXEMPTY];
  assign clr_pause = clr_write && hwdata[IRQ_PAUSE];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_d_r <= 1'b0;
      raw_r    <= '0;
      irq      <= 1'b0;
    end else begin
      busy_d_r <= tx_busy;
      // set wins over a clear in the same cycle
      if (busy_d_r && !tx_busy) begin
        raw_r[IRQ_TXEMPTY] <= 1'b1;
      end else if (clr_txe) begin
        raw_r[IRQ_TXEMPTY] <= 1'b0;
      end
      if (pause_set) begin
        raw_r[IRQ_PAUSE] <= 1'b1;
      end else if (pause_clr || clr_pause) begin
        raw_r[IRQ_PAUSE] <= 1'b0;
      end
      raw_r[IRQ_N-1:IRQ_EXT_LSB] <= irq_ext_raw;
      irq <= |(raw_r & mask_r);
    end
  end

  // ---------------- assertions ----------------
  property p_rts_off;
    @(posedge hclk) disable iff (!hresetn)
      ctrl_r.rts_en && at_trig |=> rts_n;
  endproperty
  a_rts_off: assert property (p_rts_off) else $error("request not released at watermark");

  property p_rts_on;
    @(posedge hclk) disable iff (!hresetn)
      ctrl_r.rts_en && !at_trig |=> !rts_n;
  endproperty
  a_rts_on: assert property (p_rts_on) else $error("request not asserted below watermark");

  property p_cts_gate;
    @(posedge hclk) disable iff (!hresetn)
      tx_start_ok |-> $past(!ctrl_r.cts_en || !cts_n);
  endproperty
  a_cts_gate: assert property (p_cts_gate) else $error("start allowed while clear deasserted");

  property p_cts_off;
    @(posedge hclk) disable iff (!hresetn)
      ctrl_r.en && !ctrl_r.cts_en && tx_fifo_not_empty && !paused_r && !tx_insert_valid
      ##1 $stable(ctrl_r) |-> tx_start_ok;
  endproperty
  a_cts_off: assert property (p_cts_off) else $error("send blocked without clear control");

  property p_pause_halts;
    @(posedge hclk) disable iff (!hresetn)
      pause_set && !soft_r.special |=> paused_r ##1 !tx_start_ok;
  endproperty
  a_pause_halts: assert property (p_pause_halts) else $error("pause did not halt sender");

  property p_special_runs;
    @(posedge hclk) disable iff (!hresetn)
      soft_r.special |=> !paused_r;
  endproperty
  a_special_runs: assert property (p_special_runs) else $error("special mode halted sender");

  property p_no_store_match;
    @(posedge hclk) disable iff (!hresetn)
      rx_char_valid && soft_rx && !paused_r && pause_hit |=> !rx_store && raw_r[IRQ_PAUSE];
  endproperty
  a_no_store_match: assert property (p_no_store_match) else $error("pause char stored");

  property p_txempty;
    @(posedge hclk) disable iff (!hresetn)
      $fell(tx_busy) |=> raw_r[IRQ_TXEMPTY];
  endproperty
  a_txempty: assert property (p_txempty) else $error("empty flag missed on busy fall");

  property p_irq_line;
    @(posedge hclk) disable iff (!hresetn)
      ##1 irq == |($past(raw_r) & $past(mask_r));
  endproperty
  a_irq_line: assert property (p_irq_line) else $error("interrupt line wrong");

  property p_remote_set;
    @(posedge hclk) disable iff (!hresetn)
      $rose(remote_stopped_r) |-> $past(tx_insert_ack && tx_insert_valid);
  endproperty
  a_remote_set: assert property (p_remote_set) else $error("remote stop flag set early");

endmodule // uart_flow_control_irq

// File: pkg/uart_flow_pkg.sv
package uart_flow_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_FLAG   = 8'h18;
  localparam logic [7:0] OFS_DIVISOR_INTEGER = 8'h24;
  localparam logic [7:0] OFS_DIVFRC = 8'h28;
  localparam logic [7:0] OFS_CTRL   = 8'h30;
  localparam logic [7:0] OFS_LEVEL  = 8'h34;
  localparam logic [7:0] OFS_MASK   = 8'h38;
  localparam logic [7:0] OFS_RAW    = 8'h3C;
  localparam logic [7:0] OFS_MIS    = 8'h40;
  localparam logic [7:0] OFS_CLR    = 8'h44;
  localparam logic [7:0] OFS_SOFT   = 8'h50;
  localparam logic [7:0] OFS_RES1   = 8'h54;
  localparam logic [7:0] OFS_RES2   = 8'h58;
  localparam logic [7:0] OFS_PAU1   = 8'h5C;
  localparam logic [7:0] OFS_PAU2   = 8'h60;
  // port control field positions
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_OVS_BIT = 3;
  localparam int CTRL_RTS_BIT = 14;
  localparam int CTRL_CTS_BIT = 15;
  // flag register field positions
  localparam int FLAG_BUSY_BIT = 3;
  localparam int FLAG_RSTP_BIT = 9;
  // level select field
  localparam int LVL_LSB = 3;
  localparam logic [2:0] LVL_RESET = 3'h2;
  // interrupt source positions
  localparam int IRQ_N       = 6;
  localparam int IRQ_TXEMPTY = 0;
  localparam int IRQ_PAUSE   = 1;
  localparam int IRQ_EXT_LSB = 2;
  // oversample periods in baud ticks
  localparam logic [3:0] OVS16_LAST = 4'hF;
  localparam logic [3:0] OVS8_LAST  = 4'h7;

  typedef struct packed {
    logic cts_en;
    logic rts_en;
    logic ovs8;
    logic en;
  } port_ctrl_t;

  typedef struct packed {
    logic       special;
    logic       any;
    logic [1:0] tx_mode;
    logic [1:0] rx_mode;
    logic       global;
  } soft_ctrl_t;

  localparam port_ctrl_t CTRL_RESET = '{cts_en: 1'b0, rts_en: 1'b0, ovs8: 1'b0, en: 1'b0};
  localparam soft_ctrl_t SOFT_RESET = '0;

  typedef enum logic [2:0] {
    INS_IDLE     = 3'b000,
    INS_PAUSE_A  = 3'b001,
    INS_PAUSE_B  = 3'b010,
    INS_RESUME_A = 3'b011,
    INS_RESUME_B = 3'b100
  } ins_state_t;
endpackage

// File: tb/remote_peer.sv
`timescale 1ns/1ns
module remote_peer (
  input  wire logic hclk,            // bus clock
  input  wire logic hresetn,         // async reset, low
  input  wire logic slow,            // late replies
  input  wire logic tx_insert_valid, // char handed over
  output logic      tx_insert_ack    // char fully sent
);
  logic       due;
  logic [3:0] wait_r;
  assign due = tx_insert_valid && !tx_insert_ack && wait_r == (slow ? 4'h8 : 4'h1);
  // whole frame on the line, normal framing, then ack
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_r        <= 4'h0;
      tx_insert_ack <= 1'b0;
    end else begin
      tx_insert_ack <= due;
      if (!tx_insert_valid || tx_insert_ack) begin
        wait_r <= 4'h0;
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule // remote_peer

// File: tb/testbench.sv
`timescale 1ns/1ns
`define CK(n, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module testbench;
  import uart_flow_pkg::*;
  localparam logic [7:0] P1 = 8'h13, P2 = 8'h93, S1 = 8'h11, S2 = 8'h91;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic        rx_char_valid = 1'b0;
  logic [7:0]  rx_char_data = 8'h00;
  logic [2:0]  rx_char_err = 3'h0;
  logic [6:0]  rx_fifo_level = 7'h00;
  logic        tx_fifo_not_empty = 1'b1;
  logic        tx_busy = 1'b0;
  logic        cts_n = 1'b1;
  logic        slow = 1'b0;
  logic        hready, hresp, tx_insert_ack, rts_n, tx_start_ok, tx_insert_valid;
  logic        rx_store, baud_tick, bit_tick, irq, st;
  logic [7:0]  tx_insert_data, rx_store_data;
  logic [31:0] hrdata, rd;
  int          num_errors = 0;
  int          num_checks = 0;
  always #5 hclk = ~hclk;
  uart_flow_control_irq uut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready, .hrdata, .hreadyout(hready), .hresp, .rx_char_valid, .rx_char_data,
    .rx_char_err, .rx_fifo_level, .tx_fifo_not_empty, .tx_busy, .tx_insert_ack,
    .cts_n, .irq_ext_raw(4'h0), .rts_n, .tx_start_ok, .tx_insert_valid,
    .tx_insert_data, .rx_store, .rx_store_data, .baud_tick, .bit_tick, .irq
  );
  remote_peer peer (.hclk, .hresetn, .slow, .tx_insert_valid, .tx_insert_ack);
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    do @(posedge hclk) #1; while (s !== 1'b1 && ++n < 2000);
    if (n >= 2000) begin
      num_errors++;
      end_sim();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1 && ++n < 50);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1 && ++n < 50);
    rd = hrdata;
    if (n >= 50) begin
      num_errors++;
      end_sim();
    end
  endtask
  task automatic settle;
    repeat (3) @(posedge hclk);
    #1;
  endtask
  task automatic lvl(input logic [6:0] v);
    @(posedge hclk);
    rx_fifo_level <= v;
    settle();
  endtask
  task automatic rxc(input logic [7:0] c);
    @(posedge hclk);
    rx_char_valid <= 1'b1;
    rx_char_data <= c;
    rx_char_err <= 3'h7;
    @(posedge hclk);
    rx_char_valid <= 1'b0;
    #1;
    st = rx_store;
    settle();
  endtask
  task automatic ins(input logic [7:0] c);
    wait_hi(tx_insert_valid);
    `CK("insert char", c, tx_insert_data)
    wait_hi(tx_insert_ack);
  endtask
  task automatic meas(input int nb, input int exp);
    int n;
    n = 0;
    wait_hi(bit_tick);
    wait_hi(bit_tick);
    while (nb > 0 && n < 5000) begin
      @(posedge hclk);
      #1;
      n++;
      if (bit_tick === 1'b1) nb--;
    end
    `CK("bit period", exp, n)
  endtask
  task automatic t_regs;
    bus(0, OFS_LEVEL, 0);
    `CK("level reset", 32'h10, rd)
    `CK("rts idle", 1'b0, rts_n)
    `CK("okay", 1'b0, hresp)
    bus(1, 8'h70, 32'hFFFF_FFFF);
    bus(0, 8'h70, 0);
    `CK("unmapped", 32'h0, rd)
  endtask
  task automatic t_baud;
    bus(1, OFS_DIVISOR_INTEGER, 32'h2);
    bus(1, OFS_CTRL, 32'h1);
    meas(1, 32);
    @(posedge hclk);
    #1;
    st = baud_tick;
    @(posedge hclk);
    #1;
    `CK("baud tick", ~st, baud_tick)
    bus(1, OFS_DIVISOR_INTEGER, 32'h11);
    bus(1, OFS_DIVFRC, 32'h17);
    bus(1, OFS_CTRL, 32'h9);
    meas(8, 1111);
  endtask
  task automatic t_hand;
    bus(1, OFS_CTRL, 32'h4001);
    lvl(7'd31);
    `CK("rts below", 1'b0, rts_n)
    lvl(7'd32);
    `CK("rts full", 1'b1, rts_n)
    bus(1, OFS_CTRL, 32'h8001);
    settle();
    `CK("cts off", 1'b0, tx_start_ok)
    @(posedge hclk);
    cts_n <= 1'b0;
    settle();
    `CK("cts on", 1'b1, tx_start_ok)
    bus(1, OFS_CTRL, 32'hC001);
    lvl(7'd33);
    `CK("both", 2'b11, {rts_n, tx_start_ok})
    bus(1, OFS_CTRL, 32'h0001);
    @(posedge hclk);
    cts_n <= 1'b1;
    settle();
    `CK("free", 2'b01, {rts_n, tx_start_ok})
    lvl(7'd0);
  endtask
  task automatic t_rxflow;
    bus(1, OFS_PAU1, P1);
    bus(1, OFS_PAU2, P2);
    bus(1, OFS_RES1, S1);
    bus(1, OFS_RES2, S2);
    bus(1, OFS_MASK, 32'h2);
    for (int m = 1; m < 4; m++) begin
      bus(1, OFS_SOFT, 32'(1 + 2 * m));
      if (m != 2) rxc(P1);
      if (m != 1) rxc(P2);
      `CK("paused", 3'b001, {st, tx_start_ok, irq})
      if (m != 2) rxc(S1);
      if (m != 1) rxc(S2);
      `CK("resumed", 3'b010, {st, tx_start_ok, irq})
    end
    bus(1, OFS_SOFT, 32'h23);
    rxc(P1);
    rxc(8'h41);
    `CK("any char", 3'b110, {st, tx_start_ok, irq})
    `CK("any data", 8'h41, rx_store_data)
  endtask
  task automatic t_special;
    bus(1, OFS_SOFT, 32'h40);
    rxc(P2);
    `CK("special", 3'b111, {st, tx_start_ok, irq})
    `CK("special data", P2, rx_store_data)
    bus(0, OFS_MIS, 0);
    `CK("masked", 32'h2, rd)
    bus(1, OFS_CLR, 32'h2);
    bus(0, OFS_RAW, 0);
    `CK("special clr", 32'h0, rd)
  endtask
  task automatic t_txins;
    for (int m = 1; m < 4; m++) begin
      slow <= (m == 2);
      bus(1, OFS_SOFT, 32'(1 + 8 * m));
      @(posedge hclk);
      rx_fifo_level <= 7'd40;
      if (m != 2) ins(P1);
      if (m != 1) ins(P2);
      bus(0, OFS_FLAG, 0);
      `CK("stopped", 1'b1, rd[FLAG_RSTP_BIT])
      if (m != 3) bus(1, OFS_SOFT, 0);
      else begin
        @(posedge hclk);
        rx_fifo_level <= 7'd0;
      end
      if (m != 2) ins(S1);
      if (m != 1) ins(S2);
      bus(0, OFS_FLAG, 0);
      `CK("restarted", 1'b0, rd[FLAG_RSTP_BIT])
      lvl(7'd0);
    end
  endtask
  task automatic t_txempty;
    bus(1, OFS_MASK, 32'h1);
    @(posedge hclk);
    tx_busy <= 1'b1;
    settle();
    `CK("busy", 1'b0, irq)
    @(posedge hclk);
    tx_busy <= 1'b0;
    settle();
    `CK("tx empty", 1'b1, irq)
  endtask
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_baud();
    t_hand();
    t_rxflow();
    t_special();
    t_txins();
    t_txempty();
    end_sim();
  end
endmodule // testbench
